//--- rtl/tmr_cfg.svh
// register offsets, field positions, reset values and timing counts of the timer block
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH
// apb byte offsets
`define TMR_OFF_TIMER_RUN_AND_FLAG_CONTROL 8'h00
`define TMR_OFF_TIMER_MODE_REGISTER 8'h04
`define TMR_OFF_CFG 8'h08
`define TMR_OFF_TL0 8'h0C
`define TMR_OFF_TH0 8'h10
`define TMR_OFF_TL1 8'h14
`define TMR_OFF_TH1 8'h18
`define TMR_OFF_STAT 8'h1C
`define TMR_OFF_MASK 8'h20
`define TMR_OFF_ACK 8'h24
// reset values
`define TMR_RST_BYTE 8'h00
`define TMR_RST_EVT 4'h0
// mode codes
`define TMR_MODE_13 2'h0
`define TMR_MODE_16 2'h1
`define TMR_MODE_RELOAD 2'h2
`define TMR_MODE_SPLIT 2'h3
// byte limits
`define TMR_BYTE_MAX 8'hFF
`define TMR_LOW5_MAX 5'h1F
// prescaled clock: one tick every this many system clocks
`define TMR_PRESCALE_DIV 8'h0C
// event bits of status, mask and acknowledge registers
`define TMR_EV_TF0 0
`define TMR_EV_TF1 1
`define TMR_EV_IE0 2
`define TMR_EV_IE1 3
`endif

//--- rtl/tmr_pkg.sv
// types shared by the timer block
package tmr_pkg;
  typedef struct packed {
    logic tf1;
    logic tr1;
    logic tf0;
    logic tr0;
    logic ie1;
    logic it1;
    logic ie0;
    logic it0;
  } tmr_timer_run_and_flag_control_t;
  typedef struct packed {
    logic gate1;
    logic ct1;
    logic [1:0] t1m;
    logic t0_gate_qualifier;
    logic ct0;
    logic [1:0] t0m;
  } tmr_timer_mode_register_t;
  typedef struct packed {
    logic [3:0] rsvd;
    logic in1pl;
    logic ext_irq0_polarity;
    logic t1_sys;
    logic t0_sys;
  } tmr_cfg_t;
  typedef struct packed {
    logic ovf;
    logic [7:0] hi;
    logic [7:0] lo;
  } tmr_cnt_t;
endpackage

//--- rtl/tmr_timer01.sv
// timer 0 / timer 1 counter block with split mode and apb register access
//
// What this block does
// - mode 3 splits timer 0 into bytes
// - low byte uses timer 0 controls
// - low byte counts clock or pin
// - high byte counts clock only
// - high byte runs on timer 1 run
// - high byte overflow sets timer 1 flag
// - timer 1 mode 3 stops it
// - split: timer 1 no pin, flag
// - split: timer 1 overflow gives baud tick
// - split: timer 1 mode decides running
// - count needs run and gate condition
// - counter counts pin falling edges
`timescale 1ns/1ps
`include "tmr_cfg.svh"
module tmr_timer01 (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins, synchronous
  input wire logic t0_pin,
  input wire logic t1_pin,
  input wire logic ext_irq0_input,
  input wire logic ext_irq1_input,
  // outputs
  output tmr_pkg::tmr_timer_run_and_flag_control_t timer_run_and_flag_control_out,
  output logic baud_tick,
  output logic irq
);
  import tmr_pkg::*;

  // ********************
  // state
  // ********************
  tmr_timer_run_and_flag_control_t timer_run_and_flag_control;
  tmr_timer_mode_register_t timer_mode_register;
  tmr_cfg_t cfg;
  logic [7:0] t0_low_byte, t0_high_byte, tl1, th1;
  logic [3:0] stat, mask;
  logic [7:0] presc;
  logic t0_prev, t1_prev, act0_prev, act1_prev;
  tmr_timer_run_and_flag_control_t next_timer_run_and_flag_control;
  logic [7:0] next_tl0, next_th0, next_tl1, next_th1;
  logic [3:0] ev;

  // one step of a timer in modes 0 to 2
  function automatic tmr_cnt_t cnt_step(input logic [7:0] lo, input logic [7:0] hi,
                                        input logic [1:0] mode, input logic tick);
    tmr_cnt_t r;
    r = '{ovf: 1'b0, hi: hi, lo: lo};
    if (tick) begin
      case (mode)
        `TMR_MODE_13: begin
          r.ovf = (hi == `TMR_BYTE_MAX) && (lo[4:0] == `TMR_LOW5_MAX);
          {r.hi, r.lo[4:0]} = 13'({hi, lo[4:0]} + 13'h1);
        end
        `TMR_MODE_16: begin
          r.ovf = (hi == `TMR_BYTE_MAX) && (lo == `TMR_BYTE_MAX);
          {r.hi, r.lo} = 16'({hi, lo} + 16'h1);
        end
        `TMR_MODE_RELOAD: begin
          r.ovf = (lo == `TMR_BYTE_MAX);
          r.lo = r.ovf ? hi : 8'(lo + 8'h1);
        end
        default: r.ovf = 1'b0;
      endcase
    end
    return r;
  endfunction

  // ********************
  // apb decode
  // ********************
  logic acc, wr;
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  logic wr_timer_run_and_flag_control, wr_tl0, wr_th0, wr_tl1, wr_th1, wr_ack;
  assign wr_timer_run_and_flag_control = wr && (paddr == `TMR_OFF_TIMER_RUN_AND_FLAG_CONTROL);
  assign wr_tl0 = wr && (paddr == `TMR_OFF_TL0);
  assign wr_th0 = wr && (paddr == `TMR_OFF_TH0);
  assign wr_tl1 = wr && (paddr == `TMR_OFF_TL1);
  assign wr_th1 = wr && (paddr == `TMR_OFF_TH1);
  assign wr_ack = wr && (paddr == `TMR_OFF_ACK);

  // ********************
  // clock sources and pins
  // ********************
  logic presc_tick, t0_fall, t1_fall, act0, act1;
  logic t0_clk, t1_clk;
  assign presc_tick = (presc == 8'(`TMR_PRESCALE_DIV - 8'h1));
  assign t0_fall = t0_prev && !t0_pin;
  assign t1_fall = t1_prev && !t1_pin;
  // polarity 0 means active low input
  assign act0 = cfg.ext_irq0_polarity ? ext_irq0_input : !ext_irq0_input;
  assign act1 = cfg.in1pl ? ext_irq1_input : !ext_irq1_input;
  assign t0_clk = cfg.t0_sys || presc_tick;
  assign t1_clk = cfg.t1_sys || presc_tick;

  // prescaler and pin history
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      presc <= `TMR_RST_BYTE;
      {t0_prev, t1_prev, act0_prev, act1_prev} <= `TMR_RST_EVT;
    end else begin
      presc <= presc_tick ? `TMR_RST_BYTE : 8'(presc + 8'h1);
      {t0_prev, t1_prev, act0_prev, act1_prev} <= {t0_pin, t1_pin, act0, act1};
    end
  end

  // ********************
  // counting
  // ********************
  logic split, t0_run, t0_tick, th0_tick, t1_run, t1_tick;
  logic tl0_ovf, th0_ovf, t1_ovf, t0_ovf;
  tmr_cnt_t c0, c1;
  assign split = (timer_mode_register.t0m == `TMR_MODE_SPLIT);
  assign t0_run = timer_run_and_flag_control.tr0 && (!timer_mode_register.t0_gate_qualifier || act0);
  assign t0_tick = t0_run && (timer_mode_register.ct0 ? t0_fall : t0_clk);
  assign th0_tick = split && timer_run_and_flag_control.tr1 && t0_clk;
  // in split mode timer 1 ignores its run bit; mode 3 stops it either way
  assign t1_run = (timer_mode_register.t1m != `TMR_MODE_SPLIT)
                  && (split || timer_run_and_flag_control.tr1)
                  && (!timer_mode_register.gate1 || act1);
  // external pin is never a source while timer 0 is split
  assign t1_tick = t1_run && ((timer_mode_register.ct1 && !split) ? t1_fall : t1_clk);
  assign tl0_ovf = split && t0_tick && (t0_low_byte == `TMR_BYTE_MAX);
  assign th0_ovf = th0_tick && (t0_high_byte == `TMR_BYTE_MAX);
  assign c0 = cnt_step(t0_low_byte, t0_high_byte, timer_mode_register.t0m, t0_tick);
  assign c1 = cnt_step(tl1, th1, timer_mode_register.t1m, t1_tick);
  assign t0_ovf = split ? tl0_ovf : c0.ovf;
  assign t1_ovf = c1.ovf;

  // next counter values; a software write wins over a count
  always_comb begin
    next_tl0 = split ? (t0_tick ? 8'(t0_low_byte + 8'h1) : t0_low_byte) : c0.lo;
    next_th0 = split ? (th0_tick ? 8'(t0_high_byte + 8'h1) : t0_high_byte) : c0.hi;
    next_tl1 = c1.lo;
    next_th1 = c1.hi;
    if (wr_tl0) next_tl0 = pwdata[7:0];
    if (wr_th0) next_th0 = pwdata[7:0];
    if (wr_tl1) next_tl1 = pwdata[7:0];
    if (wr_th1) next_th1 = pwdata[7:0];
  end

  // counter registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      t0_low_byte <= `TMR_RST_BYTE;
      t0_high_byte <= `TMR_RST_BYTE;
      tl1 <= `TMR_RST_BYTE;
      th1 <= `TMR_RST_BYTE;
    end else begin
      t0_low_byte <= next_tl0;
      t0_high_byte <= next_th0;
      tl1 <= next_tl1;
      th1 <= next_th1;
    end
  end

  // ********************
  // control flags
  // ********************
  logic set_tf0, set_tf1, set_ie0, set_ie1;
  assign set_tf0 = t0_ovf;
  // timer 1 overflow only reaches its flag when timer 0 is whole
  assign set_tf1 = split ? th0_ovf : t1_ovf;
  assign set_ie0 = timer_run_and_flag_control.it0 && act0 && !act0_prev;
  assign set_ie1 = timer_run_and_flag_control.it1 && act1 && !act1_prev;

  // flag update: hardware set beats software or vector clear
  always_comb begin
    next_timer_run_and_flag_control = wr_timer_run_and_flag_control ? tmr_timer_run_and_flag_control_t'(pwdata[7:0]) : timer_run_and_flag_control;
    if (wr_ack) begin
      if (pwdata[`TMR_EV_TF0]) next_timer_run_and_flag_control.tf0 = 1'b0;
      if (pwdata[`TMR_EV_TF1]) next_timer_run_and_flag_control.tf1 = 1'b0;
      if (pwdata[`TMR_EV_IE0] && timer_run_and_flag_control.it0) next_timer_run_and_flag_control.ie0 = 1'b0;
      if (pwdata[`TMR_EV_IE1] && timer_run_and_flag_control.it1) next_timer_run_and_flag_control.ie1 = 1'b0;
    end
    if (set_tf0) next_timer_run_and_flag_control.tf0 = 1'b1;
    if (set_tf1) next_timer_run_and_flag_control.tf1 = 1'b1;
    // level mode: flag follows the active input
    next_timer_run_and_flag_control.ie0 = next_timer_run_and_flag_control.it0 ? (next_timer_run_and_flag_control.ie0 || set_ie0) : act0;
    next_timer_run_and_flag_control.ie1 = next_timer_run_and_flag_control.it1 ? (next_timer_run_and_flag_control.ie1 || set_ie1) : act1;
  end

  // control register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      timer_run_and_flag_control <= tmr_timer_run_and_flag_control_t'(`TMR_RST_BYTE);
    end else begin
      timer_run_and_flag_control <= next_timer_run_and_flag_control;
    end
  end

  // mode and config registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      timer_mode_register <= tmr_timer_mode_register_t'(`TMR_RST_BYTE);
      cfg <= tmr_cfg_t'(`TMR_RST_BYTE);
    end else begin
      if (wr && (paddr == `TMR_OFF_TIMER_MODE_REGISTER)) timer_mode_register <= tmr_timer_mode_register_t'(pwdata[7:0]);
      if (wr && (paddr == `TMR_OFF_CFG)) cfg <= tmr_cfg_t'({4'h0, pwdata[3:0]});
    end
  end

  // ********************
  // interrupt status
  // ********************
  logic [3:0] next_stat;
  assign ev = {set_ie1 || (!timer_run_and_flag_control.it1 && act1 && !act1_prev),
               set_ie0 || (!timer_run_and_flag_control.it0 && act0 && !act0_prev),
               set_tf1, set_tf0};
  // write one clears, a new event in the same cycle stays set
  always_comb begin
    next_stat = stat;
    if (wr && (paddr == `TMR_OFF_STAT)) next_stat = stat & ~pwdata[3:0];
    next_stat = next_stat | ev;
  end

  // status, mask, irq and baud tick
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stat <= `TMR_RST_EVT;
      mask <= `TMR_RST_EVT;
      irq <= 1'b0;
      baud_tick <= 1'b0;
      timer_run_and_flag_control_out <= tmr_timer_run_and_flag_control_t'(`TMR_RST_BYTE);
    end else begin
      stat <= next_stat;
      if (wr && (paddr == `TMR_OFF_MASK)) mask <= pwdata[3:0];
      irq <= |(next_stat & ((wr && (paddr == `TMR_OFF_MASK)) ? pwdata[3:0] : mask));
      baud_tick <= t1_ovf;
      timer_run_and_flag_control_out <= next_timer_run_and_flag_control;
    end
  end

  // ********************
  // apb read and answer
  // ********************
  logic [7:0] rd;
  logic hit;
  always_comb begin
    hit = 1'b1;
    case (paddr)
      `TMR_OFF_TIMER_RUN_AND_FLAG_CONTROL: rd = timer_run_and_flag_control;
      `TMR_OFF_TIMER_MODE_REGISTER: rd = timer_mode_register;
      `TMR_OFF_CFG: rd = cfg;
      `TMR_OFF_TL0: rd = t0_low_byte;
      `TMR_OFF_TH0: rd = t0_high_byte;
      `TMR_OFF_TL1: rd = tl1;
      `TMR_OFF_TH1: rd = th1;
      `TMR_OFF_STAT: rd = {4'h0, stat};
      `TMR_OFF_MASK: rd = {4'h0, mask};
      `TMR_OFF_ACK: rd = `TMR_RST_BYTE;
      default: begin
        rd = `TMR_RST_BYTE;
        hit = 1'b0;
      end
    endcase
  end

  // answer one cycle after setup; data is sampled then, so counters may move past it
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      prdata <= (psel && !penable && !pwrite) ? {24'h0, rd} : 32'h0;
      pslverr <= psel && !penable && !hit;
    end
  end

  // ********************
  // checks
  // ********************
  sequence s_th0_wrap;
    split && th0_tick && (t0_high_byte == `TMR_BYTE_MAX);
  endsequence
  sequence s_no_wr_t1;
    !wr_tl1 && !wr_th1;
  endsequence

  a_split_low_ovf: assert property (@(posedge clock) disable iff (!rst_n)
    tl0_ovf |=> timer_run_and_flag_control.tf0 && (t0_low_byte == 8'h00 || $past(wr_tl0)))
    else $error("low byte overflow lost");
  a_th0_run_gate: assert property (@(posedge clock) disable iff (!rst_n)
    split && !timer_run_and_flag_control.tr1 && !wr_th0 |=> $stable(t0_high_byte))
    else $error("high byte ran without timer 1 run");
  a_th0_sets_tf1: assert property (@(posedge clock) disable iff (!rst_n)
    s_th0_wrap |=> timer_run_and_flag_control.tf1 ##1 stat[`TMR_EV_TF1])
    else $error("high byte overflow missed flag");
  a_t1_mode3_idle: assert property (@(posedge clock) disable iff (!rst_n)
    (timer_mode_register.t1m == `TMR_MODE_SPLIT) and s_no_wr_t1 |=> $stable({tl1, th1}))
    else $error("timer 1 counted in mode 3");
  a_t1_no_flag: assert property (@(posedge clock) disable iff (!rst_n)
    split && !timer_run_and_flag_control.tf1 && !th0_ovf && !wr_timer_run_and_flag_control |=> !timer_run_and_flag_control.tf1)
    else $error("timer 1 set flag while split");
  a_t1_baud_tick: assert property (@(posedge clock) disable iff (!rst_n)
    split && t1_ovf |=> baud_tick ##1 !baud_tick || $past(t1_ovf))
    else $error("baud tick missing");
  a_run_gate: assert property (@(posedge clock) disable iff (!rst_n)
    !timer_run_and_flag_control.tr0 && !wr_tl0 |=> $stable(t0_low_byte))
    else $error("timer 0 counted while stopped");
  a_pin_edge: assert property (@(posedge clock) disable iff (!rst_n)
    timer_mode_register.ct0 && !t0_fall && !wr_tl0 |=> $stable(t0_low_byte))
    else $error("counter moved without pin edge");
  a_vector_clr: assert property (@(posedge clock) disable iff (!rst_n)
    wr_ack && pwdata[`TMR_EV_TF0] && !set_tf0 |=> !timer_run_and_flag_control.tf0)
    else $error("vector did not clear flag");
  a_edge_flag: assert property (@(posedge clock) disable iff (!rst_n)
    timer_run_and_flag_control.it0 && act0 && !act0_prev && !wr_timer_run_and_flag_control |=> timer_run_and_flag_control.ie0)
    else $error("edge flag not set");
endmodule

//--- testbench/tmr_pins.sv
// pin model for the count inputs and the gate / interrupt inputs
`timescale 1ns/1ps
module tmr_pins (
  // clock
  input wire logic clock,
  // pins toward the timer
  output logic t0_pin,
  output logic t1_pin,
  output logic ext_irq0_input,
  output logic ext_irq1_input
);
  // idle high: after reset the gate inputs are active low, so idle means inactive
  initial begin
    t0_pin = 1'b1;
    t1_pin = 1'b1;
    ext_irq0_input = 1'b1;
    ext_irq1_input = 1'b1;
  end
  // falling-edge pulses on both count pins, each level held two clocks so the sampler sees it
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clock);
      t0_pin <= 1'b0;
      t1_pin <= 1'b0;
      repeat (2) @(posedge clock);
      t0_pin <= 1'b1;
      t1_pin <= 1'b1;
      @(posedge clock);
    end
  endtask
  // set one interrupt input just after an edge
  task automatic set_ext(input int i, input logic v);
    @(posedge clock);
    if (i == 0) ext_irq0_input <= v;
    else ext_irq1_input <= v;
  endtask
endmodule

//--- testbench/testbench.sv
// self-checking bench for the timer 0 split-mode block
`timescale 1ns/1ps
`include "tmr_cfg.svh"
module testbench;
  import tmr_pkg::*;
  // ****
  // signals
  // ****
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic t0_pin;
  logic t1_pin;
  logic ext_irq0_input;
  logic ext_irq1_input;
  tmr_timer_run_and_flag_control_t timer_run_and_flag_control_out;
  logic baud_tick;
  logic irq;
  logic [31:0] rd;
  logic er;
  int fails = 0;
  int tests_run = 0;
  int ticks = 0;
  int k;
  int exp_lo;
  always #4 clock = ~clock;
  tmr_timer01 dut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .t0_pin(t0_pin), .t1_pin(t1_pin), .ext_irq0_input(ext_irq0_input),
    .ext_irq1_input(ext_irq1_input), .timer_run_and_flag_control_out(timer_run_and_flag_control_out), .baud_tick(baud_tick), .irq(irq));
  tmr_pins pins (.clock(clock), .t0_pin(t0_pin), .t1_pin(t1_pin), .ext_irq0_input(ext_irq0_input),
    .ext_irq1_input(ext_irq1_input));
  // baud_tick is high for one cycle per timer 1 overflow, back to back in reload mode with TH1 at FF, so count it at every edge
  always @(posedge clock) if (baud_tick === 1'b1) ticks++;
  // ****
  // tasks
  // ****
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", s, e, g);
      fails++;
    end
  endtask
  // one apb transfer; an edge passes first so psel is never set twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // look at the answer mid-cycle, where it has settled, then let the commit edge pass
    do begin
      @(negedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      final_report;
    end
    rd = prdata;
    er = pslverr;
    @(posedge clock);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic rc(input string s, input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk(s, {24'h0, e}, rd);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ****
  // tests
  // ****
  // watchdog: the tests need well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    final_report;
  end
  initial begin
    void'($urandom(83));
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    // reset value, read back, unmapped word
    rc("control reset", `TMR_OFF_TIMER_RUN_AND_FLAG_CONTROL, 8'h00);
    wr(`TMR_OFF_TIMER_RUN_AND_FLAG_CONTROL, 8'h05);
    rc("control rw", `TMR_OFF_TIMER_RUN_AND_FLAG_CONTROL, 8'h05);
    k = $urandom_range(0, 53);
    apb(1'b0, 8'h28 + 8'(4 * k), 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    $display("test registers done");
    // split mode: low byte counts pin edges through a wrap, high byte idle
    k = $urandom_range(1, 4);
    exp_lo = 256 - k;
    wr(`TMR_OFF_TIMER_MODE_REGISTER, 8'h07);
    wr(`TMR_OFF_TL0, 8'(exp_lo));
    wr(`TMR_OFF_TIMER_RUN_AND_FLAG_CONTROL, 8'h10);
    pins.pulse(k + 1);
    exp_lo = (exp_lo + k + 1) % 256;
    rc("low byte", `TMR_OFF_TL0, 8'(exp_lo));
    rc("low flag", `TMR_OFF_TIMER_RUN_AND_FLAG_CONTROL, 8'h30);
    rc("high byte", `TMR_OFF_TH0, 8'h00);
    $display("test split low byte done");
    // gate held closed, then opened; level and edge interrupt flags
    wr(`TMR_OFF_TIMER_MODE_REGISTER, 8'h0F);
    wr(`TMR_OFF_TL0, 8'h10);
    wr(`TMR_OFF_TIMER_RUN_AND_FLAG_CONTROL, 8'h10);
    pins.pulse(3);
    rc("gated low byte", `TMR_OFF_TL0, 8'h10);
    pins.set_ext(0, 1'b0);
    pins.pulse(2);
    rc("open low byte", `TMR_OFF_TL0, 8'h12);
    rc("level flag", `TMR_OFF_TIMER_RUN_AND_FLAG_CONTROL, 8'h12);
    pins.set_ext(0, 1'b1);
    rc("level flag gone", `TMR_OFF_TIMER_RUN_AND_FLAG_CONTROL, 8'h10);
    wr(`TMR_OFF_TIMER_RUN_AND_FLAG_CONTROL, 8'h14);
    pins.set_ext(1, 1'b0);
    repeat (2) @(posedge clock);
    pins.set_ext(1, 1'b1);
    rc("edge flag", `TMR_OFF_TIMER_RUN_AND_FLAG_CONTROL, 8'h1C);
    wr(`TMR_OFF_ACK, 8'h08);
    rc("edge flag acked", `TMR_OFF_TIMER_RUN_AND_FLAG_CONTROL, 8'h14);
    rc("status", `TMR_OFF_STAT, 8'h0D);
    chk("irq masked", 32'h0, {31'h0, irq});
    $display("test gate and flags done");
    // high byte on timer 1 run, overflow lands in timer 1 flag and interrupt
    wr(`TMR_OFF_TIMER_RUN_AND_FLAG_CONTROL, 8'h00);
    wr(`TMR_OFF_STAT, 8'h0F);
    wr(`TMR_OFF_CFG, 8'h01);
    wr(`TMR_OFF_TIMER_MODE_REGISTER, 8'h03);
    wr(`TMR_OFF_TH0, 8'hF0);
    wr(`TMR_OFF_MASK, 8'h02);
    wr(`TMR_OFF_TIMER_RUN_AND_FLAG_CONTROL, 8'h40);
    repeat (30) @(posedge clock);
    rc("high overflow", `TMR_OFF_TIMER_RUN_AND_FLAG_CONTROL, 8'hC0);
    chk("control out", 32'hC0, {24'h0, timer_run_and_flag_control_out});
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(`TMR_OFF_TIMER_RUN_AND_FLAG_CONTROL, 8'h80);
    wr(`TMR_OFF_ACK, 8'h02);
    rc("flag acked", `TMR_OFF_TIMER_RUN_AND_FLAG_CONTROL, 8'h00);
    wr(`TMR_OFF_STAT, 8'h02);
    repeat (2) @(posedge clock);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test split high byte done");
    // timer 1 beside a split timer 0: every mode, run bit left clear
    for (int m = 0; m < 4; m++) begin
      wr(`TMR_OFF_TIMER_MODE_REGISTER, 8'h33);
      wr(`TMR_OFF_CFG, 8'h03);
      wr(`TMR_OFF_TL1, 8'hFF);
      wr(`TMR_OFF_TH1, 8'hFF);
      ticks = 0;
      wr(`TMR_OFF_TIMER_MODE_REGISTER, 8'(8'h03 | (m << 4)));
      repeat (20) @(posedge clock);
      chk("baud ticks", 32'(m != 3), 32'(ticks > 0));
      rc("no timer 1 flag", `TMR_OFF_TIMER_RUN_AND_FLAG_CONTROL, 8'h00);
    end
    $display("test timer 1 modes done");
    final_report;
  end
endmodule
